// ---- design/ctl_port.sv ----
// Contract
// - serve as bus target at 100 kHz and 400 kHz, single and multi byte.
// - target only; never arbitrates and never stretches the clock.
// - all bytes are eight bits, most significant bit first.
// - acknowledge a received byte by holding sda low in ninth clock.
// - sda changes only while scl is low outside start and stop.
// - strap low gives the lower address, high or open the higher.
// - strap sampled after reset release and held until next reset.
// - strap pin becomes fault output through second system control register.
// - after address change only the new address is answered.
// - low subaddresses take single bytes; upper ones whole four-byte words. The code takes whole 20-byte sets at biquad subaddresses 0x29 to 0x3C.
// - multi-byte read returns successive bytes while master acknowledges.
// - unused bit positions of a read subaddress return zero.
// - bytes counted per subaddress; early stop or restart discards partial set.
// - sequential write commits full sets, advances, drops incomplete last set.
// - no limit on bytes between start and stop.
// - write is address, subaddress, data, each acknowledged by device.
// - every data byte of a multi-byte write is acknowledged.
// - read is subaddress write, repeated start with read bit, then data.
// - bit zero of second system control register selects fault output.
// - fault output drives low on shutdown fault, high when normal.
// - latched fault copy in error status bit one, cleared by bus write.
`timescale 1ns/1ps
module ctl_port
  import ctl_port_pkg::*;
(
  input  wire logic       clk_sys,      // system clock, 125 MHz
  input  wire logic       rst_b,        // async reset, active low
  input  wire logic       scl_in,       // bus clock pin
  input  wire logic       sda_in,       // bus data pin level
  output logic            sda_out,      // bus data drive value, always 0
  output logic            sda_oe_b,     // low while pulling sda low
  input  wire logic       strap_in,     // strap pin level
  output logic            strap_out,    // strap pin drive value in fault mode
  output logic            strap_oe_b,   // low while strap pin is driven
  input  wire logic       fault_in,     // shutdown fault from protection logic
  output logic [7:0]      serial_fmt,   // serial format select
  output logic [7:0]      sys_ctrl2     // second system control register
);
  // ********************************************************
  // line events
  // ********************************************************
  ctl_link_if lnk ();

  // the sampler brings both pins into this clock domain before any decode
  line_sampler i_line_sampler (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ev      (lnk.src)
  );

  // ********************************************************
  // state
  // ********************************************************
  // ST_IGNORE parks a transaction that is not ours until the next start or stop
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA, ST_IGNORE} state_t;

  state_t      state_q;
  logic [3:0]  bit_cnt_q;     // 0..7 data bits, 8 is the ack slot
  logic [7:0]  shift_q;       // receive shift register
  logic [7:0]  tx_q;          // transmit shift register
  logic        ack_drive_q;   // pulling sda low for ack
  logic        tx_drive_q;    // driving a data zero
  logic        rd_mode_q;     // current phase is a read
  logic        mack_q;        // master acknowledged last read byte
  logic [7:0]  sub_q;         // current subaddress
  logic [4:0]  byte_cnt_q;    // bytes received for current subaddress
  logic [159:0] stage_q;      // partial write data
  logic [6:0]  taddr_q;       // latched target address
  logic        strap_done_q;  // strap sampled since reset
  logic        unlock_q;      // unlock key accepted
  logic [1:0]  strap_sync_q;  // strap synchroniser
  logic [1:0]  fault_sync_q;  // fault synchroniser
  logic [7:0]  serial_fmt_q;
  logic [7:0]  sys_ctrl2_q;
  logic        fault_latch_q;
  logic        start_fall_q;  // closing scl fall of a start still to come

  // full byte count needed before a subaddress is committed
  // a short write to the upper range is therefore dropped at stop
  function automatic logic [4:0] set_size(input logic [7:0] sub);
    if (sub < SUB_WIDE_FIRST)
      set_size = 5'd1;
    else if (sub >= BIQUAD_FIRST && sub <= BIQUAD_LAST)
      set_size = BIQUAD_BYTES;
    else
      set_size = {2'b00, WORD_BYTES};
  endfunction

  // byte of a read subaddress; narrow registers sit in the low byte
  function automatic logic [7:0] read_byte(input logic [7:0] sub, input logic [4:0] idx,
                                           input logic [7:0] fmt, input logic [7:0] c2,
                                           input logic flt);
    logic [7:0] v;
    v = 8'h00;
    if (sub < SUB_WIDE_FIRST) begin
      unique case (sub)
        SUB_ERROR_STATUS: v = {6'd0, flt, 1'b0};
        SUB_SERIAL_FMT:   v = fmt;
        SUB_SYS_CTRL2:    v = c2;
        default:          v = 8'h00;
      endcase
    end
    // upper range words hold nothing readable and return zero
    read_byte = (idx == 5'd0 || sub < SUB_WIDE_FIRST) ? v : 8'h00;
  endfunction

  // byte boundary, and the byte as it completes with the bit now on the wire
  wire byte_done = lnk.scl_rise && bit_cnt_q == 4'd7;
  wire [7:0] rx_byte = {shift_q[6:0], lnk.sda_lvl};
  wire [4:0] need = set_size(sub_q);
  // a read burst moves the subaddress on the same edge that loads the next
  // byte, so that byte is looked up one step ahead
  wire       rd_step   = byte_cnt_q + 5'd1 >= need;
  wire [7:0] rd_sub_nx = rd_step ? sub_q + 8'h01 : sub_q;
  wire [4:0] rd_idx_nx = rd_step ? 5'd0 : byte_cnt_q + 5'd1;
  wire [7:0] rd_first  = read_byte(sub_q, byte_cnt_q, serial_fmt_q, sys_ctrl2_q,
                                   fault_latch_q);
  wire [7:0] rd_next   = read_byte(rd_sub_nx, rd_idx_nx, serial_fmt_q, sys_ctrl2_q,
                                   fault_latch_q);

  // ********************************************************
  // strap sampling and address
  // ********************************************************
  // strap synchroniser runs through reset, so it already holds the pin level
  // at the first edge after release; a reset value there would mask a low strap
  always_ff @(posedge clk_sys) begin
    strap_sync_q <= {strap_sync_q[0], strap_in};
  end

  // fault synchroniser
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fault_sync_q <= 2'b00;
    end else begin
      fault_sync_q <= {fault_sync_q[0], fault_in};
    end
  end

  // caught after release, since async reset may only load constants
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
      taddr_q      <= TADDR_HIGH[7:1];
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      taddr_q      <= strap_sync_q[1] ? TADDR_HIGH[7:1] : TADDR_LOW[7:1];
    end else if (state_q == ST_WDATA && byte_done && sub_q == SUB_NEW_ADDR
                 && unlock_q && byte_cnt_q == 5'd3) begin
      taddr_q      <= rx_byte[6:0];
    end
  end

  // ********************************************************
  // protocol engine
  // ********************************************************
  // sda only pulled low, scl never touched
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 4'd0;
      shift_q     <= 8'h00;
      tx_q        <= 8'h00;
      ack_drive_q <= 1'b0;
      tx_drive_q  <= 1'b0;
      rd_mode_q   <= 1'b0;
      mack_q      <= 1'b0;
      start_fall_q <= 1'b0;
    end else if (lnk.stop_ev) begin
      // a stop abandons whatever byte was in flight
      state_q     <= ST_IDLE;
      ack_drive_q <= 1'b0;
      tx_drive_q  <= 1'b0;
      start_fall_q <= 1'b0;
    end else if (lnk.start_ev) begin
      state_q     <= ST_ADDR;
      bit_cnt_q   <= 4'd0;
      start_fall_q <= 1'b1;
      ack_drive_q <= 1'b0;
      tx_drive_q  <= 1'b0;
    end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
      if (lnk.scl_rise && bit_cnt_q < 4'd8) begin
        shift_q <= rx_byte;
        if (bit_cnt_q == 4'd7 && state_q == ST_ADDR) begin
          rd_mode_q <= lnk.sda_lvl;
          if (rx_byte[7:1] != taddr_q)
            state_q <= ST_IGNORE;
        end
      end else if (lnk.scl_rise && bit_cnt_q == 4'd8) begin
        mack_q <= ~lnk.sda_lvl;
      end
      if (lnk.scl_fall && start_fall_q) begin
        // the fall that closes a start carries no bit
        start_fall_q <= 1'b0;
      end else if (lnk.scl_fall) begin
        if (bit_cnt_q == 4'd7) begin
          bit_cnt_q   <= 4'd8;
          tx_drive_q  <= 1'b0;
          ack_drive_q <= state_q != ST_RDATA;
        end else if (bit_cnt_q == 4'd8) begin
          bit_cnt_q   <= 4'd0;
          ack_drive_q <= 1'b0;
          unique case (state_q)
            ST_ADDR: begin
              state_q <= rd_mode_q ? ST_RDATA : ST_SUB;
              if (rd_mode_q) begin
                tx_q       <= {rd_first[6:0], 1'b0};
                tx_drive_q <= ~rd_first[7];
              end
            end
            ST_SUB:   state_q <= ST_WDATA;
            ST_WDATA: state_q <= ST_WDATA;
            ST_RDATA: begin
              if (mack_q) begin
                tx_q       <= {rd_next[6:0], 1'b0};
                tx_drive_q <= ~rd_next[7];
              end else begin
                state_q <= ST_IGNORE;
              end
            end
            default:  state_q <= ST_IGNORE;
          endcase
        end else begin
          bit_cnt_q <= bit_cnt_q + 4'd1;
          if (state_q == ST_RDATA) begin
            tx_drive_q <= ~tx_q[7];
            tx_q       <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // ********************************************************
  // subaddress tracking and write staging
  // ********************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sub_q      <= 8'h00;
      byte_cnt_q <= 5'd0;
      stage_q    <= '0;
    end else if (lnk.start_ev || lnk.stop_ev) begin
      byte_cnt_q <= 5'd0;
    end else if (byte_done && state_q == ST_SUB) begin
      sub_q      <= rx_byte;
      byte_cnt_q <= 5'd0;
    end else if (byte_done && state_q == ST_WDATA) begin
      stage_q <= {stage_q[151:0], rx_byte};
      if (byte_cnt_q + 5'd1 == need) begin
        sub_q      <= sub_q + 8'h01;
        byte_cnt_q <= 5'd0;
      end else begin
        byte_cnt_q <= byte_cnt_q + 5'd1;
      end
    end else if (lnk.scl_fall && bit_cnt_q == 4'd8 && state_q == ST_RDATA && mack_q) begin
      // read sequencing: advance per byte, per word for upper range, per 20-byte set for biquads
      if (byte_cnt_q + 5'd1 >= need) begin
        sub_q      <= sub_q + 8'h01;
        byte_cnt_q <= 5'd0;
      end else begin
        byte_cnt_q <= byte_cnt_q + 5'd1;
      end
    end
  end

  // commit fires on the scl rise of the last bit of a complete set
  wire commit = byte_done && state_q == ST_WDATA && byte_cnt_q + 5'd1 == need;
  wire [31:0] word_in = {stage_q[23:0], rx_byte};

  // ********************************************************
  // register file
  // ********************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      serial_fmt_q <= SERIAL_FMT_RST;
      sys_ctrl2_q  <= SYS_CTRL2_RST;
      unlock_q     <= 1'b0;
    end else if (commit) begin
      unique case (sub_q)
        SUB_SERIAL_FMT: serial_fmt_q <= rx_byte;
        SUB_SYS_CTRL2:  sys_ctrl2_q  <= rx_byte;
        // a wrong key withdraws an earlier unlock as well
        // key must precede new address
        SUB_ADDR_UNLOCK: unlock_q    <= word_in == ADDR_UNLOCK_KEY;
        SUB_NEW_ADDR:    unlock_q    <= 1'b0;
        default:         unlock_q    <= unlock_q;
      endcase
    end
  end

  // sticky fault copy; a new fault wins over a clearing write
  // the pin follows the live fault, this copy remembers it for the host
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      fault_latch_q <= 1'b0;
    else if (fault_sync_q[1])
      fault_latch_q <= 1'b1;
    else if (commit && sub_q == SUB_ERROR_STATUS)
      fault_latch_q <= 1'b0;
  end

  // ********************************************************
  // pins
  // ********************************************************
  // sda is open drain: the drive value stays zero and only the enable moves
  // sampling at 8 ns covers both bus rates
  assign sda_out    = 1'b0;
  assign sda_oe_b   = ~(ack_drive_q | tx_drive_q);
  // strap stays an input until the address is latched, so its reading is clean
  // bit zero selects fault output after strap latched
  assign strap_out  = ~fault_sync_q[1];
  assign strap_oe_b = ~(strap_done_q & sys_ctrl2_q[SYS2_FAULT_OUT_BIT]);
  assign serial_fmt = serial_fmt_q;
  assign sys_ctrl2  = sys_ctrl2_q;
endmodule

// ---- design/line_sampler.sv ----
`timescale 1ns/1ps
module line_sampler (
  input  wire logic clk_sys,  // system clock
  input  wire logic rst_b,    // async reset, active low
  input  wire logic scl_in,   // raw scl pin
  input  wire logic sda_in,   // raw sda pin
  ctl_link_if.src   ev        // decoded line events
);
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;

  // two-stage synchronisers, stage one read by stage two only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  // edges and bus conditions
  assign ev.scl_rise = scl_sync_q[1] & ~scl_q;
  assign ev.scl_fall = ~scl_sync_q[1] & scl_q;
  assign ev.sda_lvl  = sda_sync_q[1];
  // start: sda falls while scl high
  assign ev.start_ev = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  // stop: sda rises while scl high
  assign ev.stop_ev  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];
endmodule

// ---- inc/ctl_link_if.sv ----
`timescale 1ns/1ps
// event strobes from the line sampler to the protocol engine
interface ctl_link_if;
  logic scl_rise;  // scl rising edge
  logic scl_fall;  // scl falling edge
  logic sda_lvl;   // synchronised sda level
  logic start_ev;  // start or repeated start
  logic stop_ev;   // stop condition
  modport src (output scl_rise, scl_fall, sda_lvl, start_ev, stop_ev);
  modport dst (input scl_rise, scl_fall, sda_lvl, start_ev, stop_ev);
endinterface

// ---- inc/ctl_port_pkg.sv ----
package ctl_port_pkg;
  // subaddress map
  localparam logic [7:0] SUB_ERROR_STATUS = 8'h02;
  localparam logic [7:0] SUB_SERIAL_FMT   = 8'h04;
  localparam logic [7:0] SUB_SYS_CTRL2    = 8'h05;
  localparam logic [7:0] SUB_ADDR_UNLOCK  = 8'hF8;
  localparam logic [7:0] SUB_NEW_ADDR     = 8'hF9;
  localparam logic [7:0] SUB_WIDE_FIRST   = 8'h20;
  // unlock key for the address change
  localparam logic [31:0] ADDR_UNLOCK_KEY = 32'hF9A5A5A5;
  // strapped target addresses, 8-bit form as printed
  localparam logic [7:0] TADDR_LOW  = 8'h54;
  localparam logic [7:0] TADDR_HIGH = 8'h56;
  // reset values
  localparam logic [7:0] SERIAL_FMT_RST = 8'h05;
  localparam logic [7:0] SYS_CTRL2_RST  = 8'h40;
  // field positions
  localparam int SYS2_FAULT_OUT_BIT = 0;
  localparam int ERR_FAULT_BIT      = 1;
  // byte counts
  localparam logic [2:0] WORD_BYTES = 3'd4;
  // biquad subaddress span
  localparam logic [7:0] BIQUAD_FIRST = 8'h29;
  localparam logic [7:0] BIQUAD_LAST  = 8'h3C;
  localparam logic [4:0] BIQUAD_BYTES = 5'd20;
endpackage

// ---- verification/bus_master_model.sv ----
`timescale 1ns/1ps
// two-wire master; scl stands high between frames, sda only pulled low
module bus_master_model (
  output logic scl,      // bus clock, driven push-pull
  output logic sda_low,  // high while pulling sda low
  input  wire logic sda  // resolved sda level
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic put_bit(input logic b);
    #31.25 sda_low = !b;
    #31.25 scl = 1'b1;
    #62.5 scl = 1'b0;
  endtask
  // sample late in the high phase so the device has settled
  task automatic get_bit(output logic b);
    #31.25 sda_low = 1'b0;
    #31.25 scl = 1'b1;
    #56 b = sda;
    #6.5 scl = 1'b0;
  endtask
  task automatic start_c();
    #31.25 sda_low = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b0;
  endtask
  task automatic stop_c();
    #31.25 sda_low = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b0;
    #31.25;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic ack_m);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!ack_m);
  endtask
endmodule

// ---- verification/ctl_port_assertions.sv ----
`timescale 1ns/1ps
module ctl_port_assertions
  import ctl_port_pkg::*;
(
  input wire logic       clk_sys,     // system clock
  input wire logic       rst_b,       // async reset, active low
  input wire logic       scl_in,      // bus clock pin
  input wire logic       sda_in,      // bus data pin level
  input wire logic       sda_out,     // bus data drive value
  input wire logic       sda_oe_b,    // low while pulling sda
  input wire logic       strap_in,    // strap pin level
  input wire logic       strap_out,   // strap drive value
  input wire logic       strap_oe_b,  // low while strap driven
  input wire logic       fault_in,    // shutdown fault
  input wire logic [7:0] serial_fmt,  // serial format select
  input wire logic [7:0] sys_ctrl2    // second system control
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // properties
  // ****************************************
  // open drain only, never a high drive that could fight the master
  property p_sda_out_zero; sda_out == 1'b0; endproperty
  a_sda_out_zero: assert property (p_sda_out_zero) else $error("sda drive value not zero");
  property p_ack_holds; $fell(sda_oe_b) |-> !sda_oe_b [*4]; endproperty
  a_ack_holds: assert property (p_ack_holds) else $error("sda pull too short");
  property p_sda_change_low; $changed(sda_oe_b) |-> !scl_in; endproperty
  a_sda_change_low: assert property (p_sda_change_low) else $error("sda moved with scl high");
  property p_reset_values; $rose(rst_b) |-> serial_fmt == 8'h05 && sys_ctrl2 == 8'h40; endproperty
  a_reset_values: assert property (p_reset_values) else $error("register reset value wrong");
  property p_fault_mode_on; sys_ctrl2[0] [*3] |-> !strap_oe_b; endproperty
  a_fault_mode_on: assert property (p_fault_mode_on) else $error("strap pin not driven");
  property p_fault_mode_off; !sys_ctrl2[0] [*3] |-> strap_oe_b; endproperty
  a_fault_mode_off: assert property (p_fault_mode_off) else $error("strap pin driven early");
  property p_fault_low; fault_in [*5] |-> !strap_out; endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault output not low");
  property p_fault_high; !fault_in [*5] |-> strap_out; endproperty
  a_fault_high: assert property (p_fault_high) else $error("fault output not high");
  c_ack: cover property ($fell(sda_oe_b));
  c_fault_mode: cover property ($fell(strap_oe_b));
  c_fault_seen: cover property (!strap_oe_b && !strap_out);
endmodule

bind ctl_port ctl_port_assertions i_ctl_port_assertions (.clk_sys(clk_sys), .rst_b(rst_b),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
  .strap_in(strap_in), .strap_out(strap_out), .strap_oe_b(strap_oe_b),
  .fault_in(fault_in), .serial_fmt(serial_fmt), .sys_ctrl2(sys_ctrl2));

// ---- verification/ctl_port_tb.sv ----
`timescale 1ns/1ps
module ctl_port_tb;
  import ctl_port_pkg::*;
  logic       clk_sys, rst_b, fault_in, strap_lvl, scl, sda_low, sda_out, sda_oe_b;
  logic       strap_out, strap_oe_b, ack;
  logic [7:0] serial_fmt, sys_ctrl2;
  wire        sda_line, strap_pin;
  int         err_total, checks;
  // pull-up on sda: low when either party pulls
  assign sda_line  = !(sda_low || (sda_oe_b === 1'b0 && sda_out === 1'b0));
  assign strap_pin = (strap_oe_b === 1'b0) ? strap_out : strap_lvl;
  ctl_port i_ctl_port (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .strap_in(strap_pin), .strap_out(strap_out),
    .strap_oe_b(strap_oe_b), .fault_in(fault_in), .serial_fmt(serial_fmt),
    .sys_ctrl2(sys_ctrl2));
  bus_master_model i_bus_master_model (.scl(scl), .sda_low(sda_low), .sda(sda_line));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic probe(input logic [6:0] a, input logic exp);
    i_bus_master_model.start_c();
    i_bus_master_model.wr_byte({a, 1'b0}, ack);
    chk(ack, exp);
    i_bus_master_model.stop_c();
  endtask
  task automatic wr_regs(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d[$]);
    probe_open(a, sub);
    foreach (d[i]) begin
      i_bus_master_model.wr_byte(d[i], ack);
      chk(ack, 1'b1);
    end
    i_bus_master_model.stop_c();
  endtask
  task automatic probe_open(input logic [6:0] a, input logic [7:0] sub);
    i_bus_master_model.start_c();
    i_bus_master_model.wr_byte({a, 1'b0}, ack);
    chk(ack, 1'b1);
    i_bus_master_model.wr_byte(sub, ack);
    chk(ack, 1'b1);
  endtask
  task automatic rd_regs(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] e[$]);
    logic [7:0] v;
    probe_open(a, sub);
    i_bus_master_model.start_c();
    i_bus_master_model.wr_byte({a, 1'b1}, ack);
    chk(ack, 1'b1);
    foreach (e[i]) begin
      i_bus_master_model.rd_byte(v, i != e.size() - 1);
      chk(v, e[i]);
    end
    i_bus_master_model.stop_c();
  endtask
  // ****************************************
  // clock, reset and watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // generous span: the whole sequence needs about 50 us of bus time
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    err_total = 0;
    checks = 0;
    rst_b = 1'b0;
    fault_in = 1'b0;
    strap_lvl = 1'b1;
    @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(serial_fmt, SERIAL_FMT_RST);
    chk(sys_ctrl2, SYS_CTRL2_RST);
    probe(7'h2A, 1'b0);
    rd_regs(7'h2B, SUB_SERIAL_FMT, '{8'h05, 8'h40});
    wr_regs(7'h2B, SUB_SERIAL_FMT, '{8'h03, 8'h41});
    repeat (4) @(posedge clk_sys);
    chk({8'h00, serial_fmt, sys_ctrl2, 7'h00, strap_oe_b}, 32'h00034100);
    #1 fault_in = 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(strap_out, 1'b0);
    #1 fault_in = 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(strap_out, 1'b1);
    rd_regs(7'h2B, SUB_ERROR_STATUS, '{8'h02});
    wr_regs(7'h2B, SUB_ERROR_STATUS, '{8'h00});
    rd_regs(7'h2B, SUB_ERROR_STATUS, '{8'h00});
    // key then new address word, sequential across two subaddresses
    wr_regs(7'h2B, SUB_ADDR_UNLOCK, '{8'hF9, 8'hA5, 8'hA5, 8'hA5,
            8'h00, 8'h00, 8'h00, 8'h2C});
    probe(7'h2B, 1'b0);
    rd_regs(7'h2C, SUB_SYS_CTRL2, '{8'h41});
    // second reset with the strap pulled down
    #1 rst_b = 1'b0;
    strap_lvl = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(strap_oe_b, 1'b1);
    probe(7'h2B, 1'b0);
    probe(7'h2A, 1'b1);
    give_verdict();
  end
endmodule
